// *** rtl/pgb_pkg.sv ***
// Constants for the peripheral disable register bank.
// Assumes a plain one-cycle register port driven by the processor core.
// Behaviour
// - Register one bit 7 disables the numeric oscillator when set.
// - Register one bits 6..0 disable timers 6..0 when set.
// - Register two bit 6 disables DAC, bit 5 disables ADC.
// - Register two bits 2,1,0 disable comparator 2, comparator 1, zero-cross.
// - Register three bit 6 disables PWM 7, bit 5 disables PWM 6.
// - Register three bits 4..0 disable capture/compare units 5..1.
// - Register four bit 6 disables the serial transceiver.
// - Register four bits 5 and 4 disable sync serial ports 2 and 1.
// - Register four bits 2,1,0 disable waveform generators 3,2,1.
// - Register five bits 7 and 6 disable measurement timers 2 and 1.
// - Register five bits 4..1 disable logic cells 4..1.
// - Register five bit 0 disables the data signal modulator.
// - Unimplemented bits ignore writes and read as zero.
// - Implemented bits are read/write and clear to zero on every reset.
// - A stored one disables a peripheral; a zero enables it.
// - Disabled peripheral is clock-stopped, reset, reads zero, releases pins.
// - Re-enabled peripheral returns in its power-on reset state.
package pgb_pkg;
   localparam int         ADDR_W   = 3;
   localparam int         DATA_W   = 8;
   localparam int         NUM_REGS = 5;
   localparam logic [2:0] OFF_CTL1 = 3'h0;
   localparam logic [2:0] OFF_CTL2 = 3'h1;
   localparam logic [2:0] OFF_CTL3 = 3'h2;
   localparam logic [2:0] OFF_CTL4 = 3'h3;
   localparam logic [2:0] OFF_CTL5 = 3'h4;
   // Writable masks; zeros mark unimplemented positions.
   localparam logic [7:0] MASK_CTL1 = 8'hFF;
   localparam logic [7:0] MASK_CTL2 = 8'h67;
   localparam logic [7:0] MASK_CTL3 = 8'h7F;
   localparam logic [7:0] MASK_CTL4 = 8'h77;
   localparam logic [7:0] MASK_CTL5 = 8'hDF;
   localparam logic [7:0] RST_CTL   = 8'h00;
   localparam int BIT_TOP = 7;
   localparam int BIT_6   = 6;
   localparam int BIT_5   = 5;
   localparam int BIT_4   = 4;
   localparam int BIT_2   = 2;
   localparam int BIT_1   = 1;
   localparam int BIT_0   = 0;
endpackage

// *** rtl/pgb_reg_if.sv ***
// Internal write/read bundle between the bank top and its register cell.
// Assumes one clock domain.
`timescale 1ns/100ps
interface pgb_reg_if;
   logic       wr_en;
   logic [7:0] wr_data;
   logic [7:0] value;
   modport master (output wr_en, output wr_data, input value);
   modport slave  (input wr_en, input wr_data, output value);
endinterface

// *** rtl/pgb_reg_cell.sv ***
// One masked 8-bit disable register.
// Assumes writes arrive as single-cycle enables.
`timescale 1ns/100ps
module pgb_reg_cell
   import pgb_pkg::*;
#(
   parameter logic [7:0] MASK = 8'hFF
)(
   input  wire logic   clk,
   input  wire logic   rst_b,
   input  wire logic   clk_en,
   pgb_reg_if.slave    bus
);
   logic [7:0] val_q;
   logic [7:0] val_d;
   // Masking on write keeps unimplemented bits at zero forever.
   assign val_d = bus.wr_data & MASK;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         val_q <= RST_CTL;
      else if (clk_en && bus.wr_en)
         val_q <= val_d;
   end
   assign bus.value = val_q;
endmodule

// *** rtl/pgb_bank.sv ***
// Peripheral disable register bank: five control registers, one
// disable line per peripheral.
// Assumes the peripherals honour their disable lines by gating clock,
// holding reset, zeroing reads and releasing pins.
`timescale 1ns/100ps
module pgb_bank
   import pgb_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   input  wire logic                    clk_en,
   input  wire logic [pgb_pkg::ADDR_W-1:0] addr,
   input  wire logic [pgb_pkg::DATA_W-1:0] wr_data,
   input  wire logic                    wr_stb,
   input  wire logic                    rd_stb,
   output logic [pgb_pkg::DATA_W-1:0]   rd_data,
   output logic                         num_osc_off,
   output logic [6:0]                   timer_off,
   output logic                         dac_off,
   output logic                         adc_off,
   output logic                         comparator2_off,
   output logic                         comparator1_off,
   output logic                         zero_cross_off,
   output logic                         pwm_unit7_off,
   output logic                         pwm_unit6_off,
   output logic [4:0]                   capcomp_off,
   output logic                         serial_xcvr_off,
   output logic                         sync_port2_off,
   output logic                         sync_port1_off,
   output logic                         wavegen3_off,
   output logic                         wavegen2_off,
   output logic                         wavegen1_off,
   output logic                         meas_timer2_off,
   output logic                         meas_timer1_off,
   output logic [3:0]                   logic_cell_off,
   output logic                         modulator_off
);
   import pgb_pkg::*;

   localparam logic [7:0] MASKS [NUM_REGS] =
      '{MASK_CTL1, MASK_CTL2, MASK_CTL3, MASK_CTL4, MASK_CTL5};
   localparam logic [2:0] OFFS [NUM_REGS] =
      '{OFF_CTL1, OFF_CTL2, OFF_CTL3, OFF_CTL4, OFF_CTL5};

   logic [7:0] regv [NUM_REGS];
   logic [7:0] rd_mux;
   logic [7:0] rd_data_q;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++)
      begin : g_reg
         pgb_reg_if rif ();
         assign rif.wr_en   = wr_stb && (addr == OFFS[gi]);
         assign rif.wr_data = wr_data;
         assign regv[gi]    = rif.value;
         pgb_reg_cell #(.MASK(MASKS[gi])) u_cell (
            .clk    (clk),
            .rst_b  (rst_b),
            .clk_en (clk_en),
            .bus    (rif.slave)
         );
      end
   endgenerate

   // Unmapped offsets read as zero; masked storage reads unused bits as 0.
   always_comb
   begin
      rd_mux = 8'h00;
      for (int i = 0; i < NUM_REGS; i++)
         if (addr == OFFS[i])
            rd_mux = regv[i];
   end

   // Read data stand in the cycle after the strobe and are held over edges where clk_en is low.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_data_q <= 8'h00;
      else if (clk_en)
         rd_data_q <= rd_stb ? rd_mux : 8'h00;
   end
   assign rd_data = rd_data_q;

   // Outputs are the stored bits directly, so a one disables.
   // Peripherals must treat a high line as clock stop plus reset.
   assign num_osc_off     = regv[0][BIT_TOP];
   assign timer_off       = regv[0][6:0];
   assign dac_off         = regv[1][BIT_6];
   assign adc_off         = regv[1][BIT_5];
   assign comparator2_off = regv[1][BIT_2];
   assign comparator1_off = regv[1][BIT_1];
   assign zero_cross_off  = regv[1][BIT_0];
   assign pwm_unit7_off   = regv[2][BIT_6];
   assign pwm_unit6_off   = regv[2][BIT_5];
   assign capcomp_off     = regv[2][4:0];
   assign serial_xcvr_off = regv[3][BIT_6];
   assign sync_port2_off  = regv[3][BIT_5];
   assign sync_port1_off  = regv[3][BIT_4];
   assign wavegen3_off    = regv[3][BIT_2];
   assign wavegen2_off    = regv[3][BIT_1];
   assign wavegen1_off    = regv[3][BIT_0];
   assign meas_timer2_off = regv[4][BIT_TOP];
   assign meas_timer1_off = regv[4][BIT_6];
   assign logic_cell_off  = regv[4][4:1];
   assign modulator_off   = regv[4][BIT_0];
endmodule

// *** testbench/pgb_bank_monitor.sv ***
// Port checker for the peripheral disable bank.
// Bound into every pgb_bank instance; sees its ports only.
`timescale 1ns/100ps
module pgb_bank_monitor
   import pgb_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       clk_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic       num_osc_off,
   input wire logic [6:0] timer_off,
   input wire logic [4:0] capcomp_off,
   input wire logic [3:0] logic_cell_off,
   input wire logic       modulator_off
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic wr_ok = clk_en && wr_stb;
   wire logic rd_ok = clk_en && rd_stb;
   a_ctl1_write: assert property (wr_ok && addr == 3'h0 |=>
      {num_osc_off, timer_off} == $past(wr_data)) else $error("ctl1 out");
   a_ctl3_write: assert property (wr_ok && addr == 3'h2 |=>
      capcomp_off == $past(wr_data[4:0])) else $error("ctl3 out");
   a_ctl5_write: assert property (wr_ok && addr == 3'h4 |=>
      {logic_cell_off, modulator_off} == $past(wr_data[4:0]))
      else $error("ctl5 out");
   a_hold_idle: assert property (!wr_ok |=>
      $stable(timer_off) && $stable(capcomp_off)) else $error("drift");
   a_read_back: assert property (rd_ok && addr == 3'h0 |=>
      rd_data == {num_osc_off, timer_off}) else $error("readback");
   a_gap_zero: assert property (rd_ok && addr == 3'h1 |=>
      (rd_data & 8'h98) == 8'h00) else $error("ctl2 gaps");
   a_unmapped_zero: assert property (rd_ok && addr > 3'h4 |=>
      rd_data == 8'h00) else $error("unmapped");
   a_rd_quiet: assert property (clk_en && !rd_stb |=>
      rd_data == 8'h00) else $error("rd quiet");
endmodule
bind pgb_bank pgb_bank_monitor u_mon (.clk, .rst_b, .clk_en, .addr,
   .wr_data, .wr_stb, .rd_stb, .rd_data, .num_osc_off, .timer_off,
   .capcomp_off, .logic_cell_off, .modulator_off);

// *** testbench/pgb_bank_tb_top.sv ***
// Self-checking bench for the peripheral disable bank.
// Assumes the port checker is bound from its own file.
`timescale 1ns/100ps
module pgb_bank_tb_top;
   import pgb_pkg::*;
   logic        clk = 0, rst_b = 0, clk_en = 1, wr_stb = 0, rd_stb = 0;
   logic        rd_q = 0;
   logic [2:0]  addr = 0, a;
   logic [7:0]  wr_data = 0, rd_data, q[$];
   logic [32:0] o;
   logic [7:0]  m [8] = '{default: 8'h00};
   logic [7:0]  msk [8] = '{MASK_CTL1, MASK_CTL2, MASK_CTL3, MASK_CTL4,
                            MASK_CTL5, 8'h00, 8'h00, 8'h00};
   int          miscompares = 0, checked = 0;
   integer      seed = 32'hAE4B;
   pgb_bank dut (.clk, .rst_b, .clk_en, .addr, .wr_data, .wr_stb, .rd_stb,
      .rd_data, .num_osc_off(o[32]), .timer_off(o[31:25]), .dac_off(o[24]),
      .adc_off(o[23]), .comparator2_off(o[22]), .comparator1_off(o[21]),
      .zero_cross_off(o[20]), .pwm_unit7_off(o[19]), .pwm_unit6_off(o[18]),
      .capcomp_off(o[17:13]), .serial_xcvr_off(o[12]),
      .sync_port2_off(o[11]), .sync_port1_off(o[10]), .wavegen3_off(o[9]),
      .wavegen2_off(o[8]), .wavegen1_off(o[7]), .meas_timer2_off(o[6]),
      .meas_timer1_off(o[5]), .logic_cell_off(o[4:1]), .modulator_off(o[0]));
   always #4 clk = ~clk;
   task automatic chk(input string n, input logic [32:0] s, e);
      checked++;
      if (s !== e)
      begin
         miscompares++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask
   // Strobes are left up between calls so no signal is driven twice.
   task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d);
      wr_stb  <= w;
      rd_stb  <= !w;
      addr    <= a;
      wr_data <= d;
      // A read is noted whatever clk_en shows now, since clk_en is sampled
      // only at the coming edge; the bench never reads with clk_en low.
      if (!w)
         q.push_back(m[a]);
      @(posedge clk);
      if (w && clk_en)
         m[a] = d & msk[a];
   endtask
   task automatic print_verdict;
      if (miscompares == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) rd_q <= rd_stb && clk_en && rst_b;
   always @(negedge clk)
      if (rd_q)
      begin
         chk("rd_data", rd_data, q.pop_front());
         chk("off", o, {m[0], m[1][6:5], m[1][2:0], m[2][6:0], m[3][6:4],
            m[3][2:0], m[4][7:6], m[4][4:0]});
      end
   initial
   begin
      #5000;
      miscompares++;
      print_verdict;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 13; i++)
      begin
         a = i[2:0];
         op(i > 4 && i < 8, a, 8'hFF);
      end
      for (int i = 0; i < 80; i++)
      begin
         if (!i[0])
            a = 3'($random(seed));
         op(!i[0], a, 8'($random(seed)));
      end
      clk_en <= 1'b0;
      op(1'b1, 3'h0, 8'h5A);
      clk_en <= 1'b1;
      op(1'b0, 3'h0, 8'h00);
      // Let the last read data be compared before reset clears them.
      rd_stb <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b0;
      m = '{default: 8'h00};
      @(posedge clk);
      rst_b <= 1'b1;
      // No peripheral sits behind the lines here, so no settle wait.
      for (int i = 0; i < 5; i++)
         op(1'b0, i[2:0], 8'h00);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      repeat (2) @(posedge clk);
      print_verdict;
   end
endmodule
